// *** verilog/acmp_pkg.sv ***
// package: register map, field positions and carrier types of the comparator control
package acmp_pkg;

  localparam int REG_W = 8;
  localparam logic [7:0] REG_RST = 8'h00;

  // per-comparator register offsets, one bank of four per comparator
  localparam logic [7:0] OFS_CON0 = 8'h00;
  localparam logic [7:0] OFS_CON1 = 8'h01;
  localparam logic [7:0] OFS_NSEL = 8'h02;
  localparam logic [7:0] OFS_PSEL = 8'h03;
  localparam logic [7:0] BANK_STRIDE = 8'h04;

  // shared registers
  localparam logic [7:0] OFS_MIRROR = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h09;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0A;
  localparam logic [7:0] OFS_SHDN_EN = 8'h0B;
  localparam logic [7:0] OFS_ANA_SEL = 8'h0C;
  localparam logic [7:0] OFS_DIR = 8'h0D;
  localparam logic [7:0] OFS_PORT = 8'h0E;

  // comparator_control_0 fields
  localparam int CON0_ENABLE = 7;
  localparam int CON0_RESULT = 6;
  localparam int CON0_INVERT = 4;
  localparam int CON0_HYST = 1;
  localparam int CON0_SYNC = 0;

  // comparator_edge_enables fields
  localparam int CON1_RISE = 1;
  localparam int CON1_FALL = 0;

  localparam int SEL_W = 3;

  // negative input select codes
  localparam logic [2:0] NSEL_IN0 = 3'h0;
  localparam logic [2:0] NSEL_IN1 = 3'h1;
  localparam logic [2:0] NSEL_IN2 = 3'h2;
  localparam logic [2:0] NSEL_IN3 = 3'h3;
  localparam logic [2:0] NSEL_REF = 3'h6;
  localparam logic [2:0] NSEL_GND = 3'h7;

  // positive input select codes
  localparam logic [2:0] PSEL_IN0 = 3'h0;
  localparam logic [2:0] PSEL_IN1 = 3'h1;
  localparam logic [2:0] PSEL_DAC = 3'h5;
  localparam logic [2:0] PSEL_REF = 3'h6;
  localparam logic [2:0] PSEL_GND = 3'h7;

  // configuration of one comparator as the channel logic sees it
  typedef struct packed {
    logic enable;
    logic invert;
    logic sync;
    logic rise_en;
    logic fall_en;
  } acmp_cfg_t;

  // one-hot switch controls towards the analog front end
  typedef struct packed {
    logic enable;
    logic hysteresis_enable;
    logic neg_gnd;
    logic neg_ref;
    logic [3:0] neg_pin;
    logic neg_opamp;
    logic pos_gnd;
    logic pos_ref;
    logic pos_dac;
    logic [1:0] pos_pin;
  } acmp_ana_t;

endpackage : acmp_pkg

// *** verilog/acmp_channel.sv ***
// one comparator: polarity, output latch, timer-1 synchronisation, edge flag
`timescale 1ns/100ps
`default_nettype none
module acmp_channel (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire acmp_pkg::acmp_cfg_t cfg_i,
  input wire logic raw_i,
  input wire logic t1_fall_i,
  input wire logic sync_hold_i,
  input wire logic flag_wr_i,
  input wire logic flag_wdata_i,
  output logic result_o,
  output logic ext_o,
  output logic flag_o
);

  logic adjusted;
  logic result_prev;
  logic sync_latch;
  logic rise;
  logic fall;
  logic edge_set;
  logic next_flag;
  logic next_latch;

  // a disabled comparator reads low before polarity, so toggling the
  // invert bit still makes an edge, and the enable bit makes one only while the raw result is high
  assign adjusted = (raw_i & cfg_i.enable) ^ cfg_i.invert;

  assign rise = result_o & ~result_prev;
  assign fall = ~result_o & result_prev;
  assign edge_set = (rise & cfg_i.rise_en) | (fall & cfg_i.fall_en);

  // set wins over a clearing write in the same cycle
  assign next_flag = edge_set | (flag_wr_i ? flag_wdata_i : flag_o);

  // latch only on a timer-1 falling edge, and not while timer 1 is stopped
  assign next_latch = (t1_fall_i & ~sync_hold_i) ? adjusted : sync_latch;

  // external path is unlatched unless synchronisation is on
  assign ext_o = cfg_i.sync ? sync_latch : adjusted;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= 1'b0;
      result_prev <= 1'b0;
      sync_latch <= 1'b0;
      flag_o <= 1'b0;
    end else begin
      result_o <= adjusted;
      result_prev <= result_o;
      sync_latch <= next_latch;
      flag_o <= next_flag;
    end
  end

endmodule : acmp_channel
`default_nettype wire

// *** verilog/acmp_control.sv ***
// comparator control top: register file, input routing, shutdown and wake
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module acmp_control #(
  parameter int NUM_CMP = 2,
  parameter int PORT_W = 8,
  parameter logic [2:0] OPAMP_NEG_CODE = 3'h2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [NUM_CMP-1:0] raw_result_i,
  input wire logic t1_clk_i,
  input wire logic t1_sysclk_src_i,
  input wire logic sleep_i,
  input wire logic [NUM_CMP-1:0] opamp_enable_i,
  input wire logic [PORT_W-1:0] pin_level_i,
  output acmp_pkg::acmp_ana_t [NUM_CMP-1:0] analog_ctrl_o,
  output logic [NUM_CMP-1:0] ext_result_o,
  output logic [NUM_CMP-1:0] shutdown_o,
  output logic [PORT_W-1:0] pin_direction_o,
  output logic irq_o,
  output logic wake_o
);

  // byte address of a per-comparator register
  function automatic logic [7:0] bank_addr(input int ch, input logic [7:0] ofs);
    logic [7:0] base;
    base = 8'(ch * int'(acmp_pkg::BANK_STRIDE));
    return base + ofs;
  endfunction : bank_addr

  // negative input switch decode
  function automatic logic [6:0] neg_decode(input logic [2:0] code);
    logic [6:0] sel;
    sel = 7'h00;
    if (code == acmp_pkg::NSEL_IN0) begin
      sel[0] = 1'b1;
    end else if (code == acmp_pkg::NSEL_IN1) begin
      sel[1] = 1'b1;
    end else if (code == acmp_pkg::NSEL_IN2) begin
      sel[2] = 1'b1;
    end else if (code == acmp_pkg::NSEL_IN3) begin
      sel[3] = 1'b1;
    end else if (code == acmp_pkg::NSEL_REF) begin
      sel[4] = 1'b1;
    end else if (code == acmp_pkg::NSEL_GND) begin
      sel[5] = 1'b1;
    end
    return sel;
  endfunction : neg_decode

  // positive input switch decode
  function automatic logic [4:0] pos_decode(input logic [2:0] code);
    logic [4:0] sel;
    sel = 5'h00;
    if (code == acmp_pkg::PSEL_IN0) begin
      sel[0] = 1'b1;
    end else if (code == acmp_pkg::PSEL_IN1) begin
      sel[1] = 1'b1;
    end else if (code == acmp_pkg::PSEL_DAC) begin
      sel[2] = 1'b1;
    end else if (code == acmp_pkg::PSEL_REF) begin
      sel[3] = 1'b1;
    end else if (code == acmp_pkg::PSEL_GND) begin
      sel[4] = 1'b1;
    end
    return sel;
  endfunction : pos_decode

  // control state, one bit or field per comparator
  logic [NUM_CMP-1:0] enable;
  logic [NUM_CMP-1:0] invert;
  logic [NUM_CMP-1:0] hyst;
  logic [NUM_CMP-1:0] sync;
  logic [NUM_CMP-1:0] rise_en;
  logic [NUM_CMP-1:0] fall_en;
  logic [2:0] nsel [NUM_CMP];
  logic [2:0] psel [NUM_CMP];

  // shared registers
  logic [NUM_CMP-1:0] irq_enable;
  logic [NUM_CMP-1:0] shdn_enable;
  logic [PORT_W-1:0] analog_select;
  logic [PORT_W-1:0] pin_dir;

  // channel outputs
  logic [NUM_CMP-1:0] result;
  logic [NUM_CMP-1:0] flag;

  // per-comparator read values
  logic [7:0] con0_rd [NUM_CMP];
  logic [7:0] con1_rd [NUM_CMP];
  logic [7:0] nsel_rd [NUM_CMP];
  logic [7:0] psel_rd [NUM_CMP];

  // timer-1 clock edge detect, sampled as an ordinary input
  logic t1_prev;
  logic t1_fall;
  logic sync_hold;

  assign t1_fall = t1_prev & ~t1_clk_i;
  assign sync_hold = sleep_i & t1_sysclk_src_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t1_prev <= 1'b0;
    end else begin
      t1_prev <= t1_clk_i;
    end
  end

  // shared register write decode
  logic wr_flag;
  logic wr_irq_en;
  logic wr_shdn;
  logic wr_ana_sel;
  logic wr_dir;

  assign wr_flag = wr_i && (addr_i == acmp_pkg::OFS_FLAG);
  assign wr_irq_en = wr_i && (addr_i == acmp_pkg::OFS_IRQ_EN);
  assign wr_shdn = wr_i && (addr_i == acmp_pkg::OFS_SHDN_EN);
  assign wr_ana_sel = wr_i && (addr_i == acmp_pkg::OFS_ANA_SEL);
  assign wr_dir = wr_i && (addr_i == acmp_pkg::OFS_DIR);

  logic [NUM_CMP-1:0] next_irq_enable;
  logic [NUM_CMP-1:0] next_shdn_enable;
  logic [PORT_W-1:0] next_analog_select;
  logic [PORT_W-1:0] next_pin_dir;

  // only implemented low bits are stored
  assign next_irq_enable = wr_irq_en ? wdata_i[NUM_CMP-1:0] : irq_enable;
  assign next_shdn_enable = wr_shdn ? wdata_i[NUM_CMP-1:0] : shdn_enable;
  assign next_analog_select = wr_ana_sel ? wdata_i[PORT_W-1:0] : analog_select;
  assign next_pin_dir = wr_dir ? wdata_i[PORT_W-1:0] : pin_dir;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_enable <= '0;
      shdn_enable <= '0;
      analog_select <= '0;
      pin_dir <= '0;
    end else begin
      irq_enable <= next_irq_enable;
      shdn_enable <= next_shdn_enable;
      analog_select <= next_analog_select;
      pin_dir <= next_pin_dir;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      logic wr_con0;
      logic wr_con1;
      logic wr_nsel;
      logic wr_psel;
      logic [6:0] neg_sel;
      logic [4:0] pos_sel;
      logic opamp_route;
      acmp_pkg::acmp_cfg_t cfg;

      assign wr_con0 = wr_i && (addr_i == bank_addr(gi, acmp_pkg::OFS_CON0));
      assign wr_con1 = wr_i && (addr_i == bank_addr(gi, acmp_pkg::OFS_CON1));
      assign wr_nsel = wr_i && (addr_i == bank_addr(gi, acmp_pkg::OFS_NSEL));
      assign wr_psel = wr_i && (addr_i == bank_addr(gi, acmp_pkg::OFS_PSEL));

      // the result bit is read-only; unimplemented bits are dropped
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          enable[gi] <= 1'b0;
          invert[gi] <= 1'b0;
          hyst[gi] <= 1'b0;
          sync[gi] <= 1'b0;
          rise_en[gi] <= 1'b0;
          fall_en[gi] <= 1'b0;
          nsel[gi] <= 3'h0;
          psel[gi] <= 3'h0;
        end else begin
          if (wr_con0) begin
            enable[gi] <= wdata_i[acmp_pkg::CON0_ENABLE];
            invert[gi] <= wdata_i[acmp_pkg::CON0_INVERT];
            hyst[gi] <= wdata_i[acmp_pkg::CON0_HYST];
            sync[gi] <= wdata_i[acmp_pkg::CON0_SYNC];
          end
          if (wr_con1) begin
            rise_en[gi] <= wdata_i[acmp_pkg::CON1_RISE];
            fall_en[gi] <= wdata_i[acmp_pkg::CON1_FALL];
          end
          if (wr_nsel) begin
            nsel[gi] <= wdata_i[acmp_pkg::SEL_W-1:0];
          end
          if (wr_psel) begin
            psel[gi] <= wdata_i[acmp_pkg::SEL_W-1:0];
          end
        end
      end

      assign cfg.enable = enable[gi];
      assign cfg.invert = invert[gi];
      assign cfg.sync = sync[gi];
      assign cfg.rise_en = rise_en[gi];
      assign cfg.fall_en = fall_en[gi];

      acmp_channel u_channel (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .cfg_i(cfg),
        .raw_i(raw_result_i[gi]),
        .t1_fall_i(t1_fall),
        .sync_hold_i(sync_hold),
        .flag_wr_i(wr_flag),
        .flag_wdata_i(wdata_i[gi]),
        .result_o(result[gi]),
        .ext_o(ext_result_o[gi]),
        .flag_o(flag[gi])
      );

      // a disabled comparator disconnects all its inputs
      assign neg_sel = enable[gi] ? neg_decode(nsel[gi]) : 7'h00;
      assign pos_sel = enable[gi] ? pos_decode(psel[gi]) : 5'h00;

      // shared pin with the amplifier output: amplifier wins
      assign opamp_route = neg_sel[OPAMP_NEG_CODE] & opamp_enable_i[gi];

      assign analog_ctrl_o[gi].enable = enable[gi];
      assign analog_ctrl_o[gi].hysteresis_enable = hyst[gi];
      assign analog_ctrl_o[gi].neg_gnd = neg_sel[5];
      assign analog_ctrl_o[gi].neg_ref = neg_sel[4];
      assign analog_ctrl_o[gi].neg_pin = neg_sel[3:0] & ~(4'(opamp_route) << OPAMP_NEG_CODE);
      assign analog_ctrl_o[gi].neg_opamp = opamp_route;
      assign analog_ctrl_o[gi].pos_gnd = pos_sel[4];
      assign analog_ctrl_o[gi].pos_ref = pos_sel[3];
      assign analog_ctrl_o[gi].pos_dac = pos_sel[2];
      assign analog_ctrl_o[gi].pos_pin = pos_sel[1:0];

      // shutdown acts on the external result, which is the timer-1 latched value while synchronisation is on
      assign shutdown_o[gi] = ext_result_o[gi] & shdn_enable[gi];

      always_comb begin
        con0_rd[gi] = acmp_pkg::REG_RST;
        con0_rd[gi][acmp_pkg::CON0_ENABLE] = enable[gi];
        con0_rd[gi][acmp_pkg::CON0_RESULT] = result[gi];
        con0_rd[gi][acmp_pkg::CON0_INVERT] = invert[gi];
        con0_rd[gi][acmp_pkg::CON0_HYST] = hyst[gi];
        con0_rd[gi][acmp_pkg::CON0_SYNC] = sync[gi];
        con1_rd[gi] = acmp_pkg::REG_RST;
        con1_rd[gi][acmp_pkg::CON1_RISE] = rise_en[gi];
        con1_rd[gi][acmp_pkg::CON1_FALL] = fall_en[gi];
        nsel_rd[gi] = {5'h00, nsel[gi]};
        psel_rd[gi] = {5'h00, psel[gi]};
      end
    end
  endgenerate

  // software waits out response and settling time itself
  // after a select change; no hardware blanking is applied

  assign irq_o = |(flag & irq_enable);
  assign wake_o = sleep_i & irq_o;
  assign pin_direction_o = pin_dir;

  // shared read values
  logic [7:0] mirror_rd;
  logic [7:0] flag_rd;
  logic [7:0] irq_en_rd;
  logic [7:0] shdn_rd;
  logic [7:0] port_rd;

  assign mirror_rd = 8'(result);
  assign flag_rd = 8'(flag);
  assign irq_en_rd = 8'(irq_enable);
  assign shdn_rd = 8'(shdn_enable);
  assign port_rd = 8'(pin_level_i & ~analog_select);

  // read mux; unmapped addresses read zero
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = acmp_pkg::REG_RST;
    if (addr_i == acmp_pkg::OFS_MIRROR) begin
      next_rdata = mirror_rd;
    end else if (addr_i == acmp_pkg::OFS_FLAG) begin
      next_rdata = flag_rd;
    end else if (addr_i == acmp_pkg::OFS_IRQ_EN) begin
      next_rdata = irq_en_rd;
    end else if (addr_i == acmp_pkg::OFS_SHDN_EN) begin
      next_rdata = shdn_rd;
    end else if (addr_i == acmp_pkg::OFS_ANA_SEL) begin
      next_rdata = 8'(analog_select);
    end else if (addr_i == acmp_pkg::OFS_DIR) begin
      next_rdata = 8'(pin_dir);
    end else if (addr_i == acmp_pkg::OFS_PORT) begin
      next_rdata = port_rd;
    end
    for (int c = 0; c < NUM_CMP; c++) begin
      if (addr_i == bank_addr(c, acmp_pkg::OFS_CON0)) begin
        next_rdata = con0_rd[c];
      end else if (addr_i == bank_addr(c, acmp_pkg::OFS_CON1)) begin
        next_rdata = con1_rd[c];
      end else if (addr_i == bank_addr(c, acmp_pkg::OFS_NSEL)) begin
        next_rdata = nsel_rd[c];
      end else if (addr_i == bank_addr(c, acmp_pkg::OFS_PSEL)) begin
        next_rdata = psel_rd[c];
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

endmodule : acmp_control
`default_nettype wire

// *** tb/acmp_control_assertions.sv ***
// checker: port-level timing and decode properties of the comparator control
`timescale 1ns/100ps
`default_nettype none
module acmp_control_assertions #(
  parameter int NUM_CMP = 2,
  parameter int PORT_W = 8,
  parameter logic [2:0] OPAMP_NEG_CODE = 3'h2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [NUM_CMP-1:0] raw_result_i,
  input wire logic t1_clk_i,
  input wire logic t1_sysclk_src_i,
  input wire logic sleep_i,
  input wire logic [NUM_CMP-1:0] opamp_enable_i,
  input wire logic [PORT_W-1:0] pin_level_i,
  input wire acmp_pkg::acmp_ana_t [NUM_CMP-1:0] analog_ctrl_o,
  input wire logic [NUM_CMP-1:0] ext_result_o,
  input wire logic [NUM_CMP-1:0] shutdown_o,
  input wire logic [PORT_W-1:0] pin_direction_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside its slot");
  chk_wake_gate: assert property (wake_o == (sleep_i && irq_o))
    else $error("wake does not follow sleep and interrupt");
  chk_shdn_src: assert property ((shutdown_o & ~ext_result_o) == '0)
    else $error("shutdown without active result");
  chk_off_switches: assert property (!analog_ctrl_o[0].enable |-> analog_ctrl_o[0][11:0] == 12'h000)
    else $error("input switch closed while disabled");
  chk_neg_onehot: assert property ($onehot0(analog_ctrl_o[0][11:5]))
    else $error("more than one negative input closed");
  chk_pos_onehot: assert property ($onehot0(analog_ctrl_o[0][4:0]))
    else $error("more than one positive input closed");
  // an interrupt may only appear from a write one or three edges back or a result change two edges back
  chk_irq_cause: assert property ($rose(irq_o) |->
    ($past(wr_i) || $past(wr_i, 3) || $past(raw_result_i, 2) != $past(raw_result_i, 3)))
    else $error("interrupt raised without cause");
  chk_irq_hold: assert property ($fell(irq_o) |-> $past(wr_i))
    else $error("interrupt dropped without a write");
endmodule : acmp_control_assertions

bind acmp_control acmp_control_assertions #(
  .NUM_CMP(NUM_CMP), .PORT_W(PORT_W), .OPAMP_NEG_CODE(OPAMP_NEG_CODE)
) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .raw_result_i(raw_result_i), .t1_clk_i(t1_clk_i), .t1_sysclk_src_i(t1_sysclk_src_i),
  .sleep_i(sleep_i), .opamp_enable_i(opamp_enable_i), .pin_level_i(pin_level_i),
  .analog_ctrl_o(analog_ctrl_o), .ext_result_o(ext_result_o), .shutdown_o(shutdown_o),
  .pin_direction_o(pin_direction_o), .irq_o(irq_o), .wake_o(wake_o)
);
`default_nettype wire

// *** tb/acmp_afe_model.sv ***
// behavioural analog front end: switches to fixed levels or the driven positive pin-0 level, compares, syncs to clk
`timescale 1ns/100ps
`default_nettype none
module acmp_afe_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire acmp_pkg::acmp_ana_t [1:0] ana_i,
  input wire logic [7:0] pos_lvl_i,
  output logic [1:0] raw_o
);
  // open negative input floats high so an unconnected choice never reads as a win
  function automatic logic [7:0] vn(input acmp_pkg::acmp_ana_t a);
    if (a.neg_gnd) return 8'h00;
    if (a.neg_ref) return 8'h50;
    if (a.neg_opamp) return 8'h60;
    for (int k = 0; k < 4; k++) if (a.neg_pin[k]) return 8'(8'h10 * (k + 1));
    return 8'hFF;
  endfunction : vn
  function automatic logic [7:0] vp(input acmp_pkg::acmp_ana_t a);
    if (a.pos_gnd) return 8'h00;
    if (a.pos_ref) return 8'h50;
    if (a.pos_dac) return 8'h25;
    if (a.pos_pin[0]) return pos_lvl_i;
    if (a.pos_pin[1]) return 8'h35;
    return 8'h00;
  endfunction : vp
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_o <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) raw_o[i] <= ana_i[i].enable && (vp(ana_i[i]) > vn(ana_i[i]));
    end
  end
endmodule : acmp_afe_model
`default_nettype wire

// *** tb/acmp_control_tb.sv ***
// testbench: register-level tests of the comparator control
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module acmp_control_tb;
  logic clk_i, rst_n_i, wr_i, rd_i, t1_clk_i, t1_sysclk_src_i, sleep_i, irq_o, wake_o;
  logic [7:0] addr_i, wdata_i, rdata_o, pin_level_i, pin_direction_o, pos_lvl;
  logic [1:0] raw_result_i, opamp_enable_i, ext_result_o, shutdown_o;
  acmp_pkg::acmp_ana_t [1:0] analog_ctrl_o;
  int failures, checks_done, cycles;
  logic [7:0] ta [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
  logic [7:0] tw [5] = '{8'h6C, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] te [5] = '{8'h00, 8'h03, 8'h07, 8'h07, 8'h00};

  acmp_control dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .raw_result_i(raw_result_i), .t1_clk_i(t1_clk_i), .t1_sysclk_src_i(t1_sysclk_src_i),
    .sleep_i(sleep_i), .opamp_enable_i(opamp_enable_i), .pin_level_i(pin_level_i),
    .analog_ctrl_o(analog_ctrl_o), .ext_result_o(ext_result_o), .shutdown_o(shutdown_o),
    .pin_direction_o(pin_direction_o), .irq_o(irq_o), .wake_o(wake_o)
  );
  acmp_afe_model afe (.clk_i(clk_i), .rst_n_i(rst_n_i), .ana_i(analog_ctrl_o), .pos_lvl_i(pos_lvl),
    .raw_o(raw_result_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask : rd
  // four edges cover model sync, result and flag stages plus margin
  task automatic lvl(input logic [7:0] v);
    @(posedge clk_i);
    pos_lvl <= v;
    settle(4);
  endtask : lvl
  task automatic t1_pulse;
    @(posedge clk_i);
    t1_clk_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t1_clk_i <= 1'b0;
    settle(3);
  endtask : t1_pulse
  function automatic logic [6:0] nexp(input logic [2:0] c);
    if (c < 3'h4) return {2'b00, 4'(4'b0001 << c), 1'b0};
    if (c == 3'h6) return 7'h20;
    if (c == 3'h7) return 7'h40;
    return 7'h00;
  endfunction : nexp
  function automatic logic [4:0] pexp(input logic [2:0] c);
    case (c)
      3'h0: return 5'h01;
      3'h1: return 5'h02;
      3'h5: return 5'h04;
      3'h6: return 5'h08;
      3'h7: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction : pexp
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      print_verdict;
    end
  end

  initial begin
    {rst_n_i, wr_i, rd_i, t1_clk_i, t1_sysclk_src_i, sleep_i} = 6'h00;
    {addr_i, wdata_i, pos_lvl} = 24'h000000;
    opamp_enable_i = 2'b00;
    pin_level_i = 8'hA5;
    {failures, checks_done, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 14; a++) rd(8'(a), 8'h00);
    rd(8'h0E, 8'hA5);
    rd(8'h3F, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ta[i], tw[i]);
      rd(ta[i], te[i]);
    end
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h82);
    `CHK(analog_ctrl_o[0].hysteresis_enable, 1'b1)
    for (int c = 0; c < 8; c++) begin
      wr(8'h02, 8'(c));
      wr(8'h03, 8'(c));
      `CHK(analog_ctrl_o[0][11:5], nexp(3'(c)))
      `CHK(analog_ctrl_o[0][4:0], pexp(3'(c)))
    end
    wr(8'h02, 8'h02);
    @(posedge clk_i);
    opamp_enable_i <= 2'b01;
    settle(1);
    `CHK(analog_ctrl_o[0][11:5], 7'h01)
    @(posedge clk_i);
    opamp_enable_i <= 2'b00;
    wr(8'h00, 8'h00);
    `CHK(analog_ctrl_o[0].enable, 1'b0)
    // both comparators: pin 0 against negative pin 0 at level 0x10
    for (int b = 0; b < 8; b += 4) begin
      wr(8'(b + 2), 8'h00);
      wr(8'(b + 3), 8'h00);
      wr(8'(b), 8'h80);
    end
    lvl(8'h20);
    rd(8'h00, 8'hC0);
    rd(8'h08, 8'h03);
    wr(8'h00, 8'h90);
    settle(3);
    rd(8'h00, 8'h90);
    rd(8'h08, 8'h02);
    wr(8'h00, 8'h80);
    wr(8'h0A, 8'h03);
    wr(8'h01, 8'h02);
    settle(3);
    wr(8'h09, 8'h00);
    lvl(8'h00);
    rd(8'h09, 8'h00);
    lvl(8'h20);
    rd(8'h09, 8'h01);
    `CHK(irq_o, 1'b1)
    @(posedge clk_i);
    sleep_i <= 1'b1;
    settle(1);
    `CHK(wake_o, 1'b1)
    @(posedge clk_i);
    sleep_i <= 1'b0;
    wr(8'h09, 8'h00);
    rd(8'h09, 8'h00);
    // rising edge lands in the very cycle of the clearing write
    wr(8'h00, 8'h90);
    wr(8'h00, 8'h80);
    wr(8'h09, 8'h00);
    rd(8'h09, 8'h01);
    wr(8'h09, 8'h00);
    wr(8'h01, 8'h01);
    lvl(8'h00);
    rd(8'h09, 8'h01);
    wr(8'h0A, 8'h00);
    `CHK(irq_o, 1'b0)
    // disabled comparator: toggling the invert bit still makes an edge
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h02);
    settle(3);
    wr(8'h09, 8'h00);
    wr(8'h00, 8'h10);
    settle(3);
    rd(8'h09, 8'h01);
    wr(8'h00, 8'h00);
    wr(8'h09, 8'h00);
    wr(8'h0B, 8'h01);
    wr(8'h00, 8'h81);
    lvl(8'h20);
    `CHK(ext_result_o, 2'b10)
    t1_pulse;
    `CHK(ext_result_o[0], 1'b1)
    `CHK(shutdown_o, 2'b01)
    @(posedge clk_i);
    sleep_i <= 1'b1;
    t1_sysclk_src_i <= 1'b1;
    lvl(8'h00);
    t1_pulse;
    `CHK(ext_result_o[0], 1'b1)
    @(posedge clk_i);
    sleep_i <= 1'b0;
    t1_pulse;
    `CHK(ext_result_o[0], 1'b0)
    `CHK(shutdown_o, 2'b00)
    wr(8'h0C, 8'h0F);
    rd(8'h0E, 8'hA0);
    wr(8'h0D, 8'h3C);
    `CHK(pin_direction_o, 8'h3C)
    print_verdict;
  end
endmodule : acmp_control_tb
`default_nettype wire
